// *** common/sebf_defs.svh ***
/*
  constants of the serial memory bus front end: register offsets, status
  field positions, reset values, address word layout and timing counts.
  assumes: included by bare name, definitions only.
*/
`ifndef SEBF_DEFS_SVH
`define SEBF_DEFS_SVH

`define SEBF_OFF_CTRL      12'h000
`define SEBF_OFF_STATUS    12'h004
`define SEBF_OFF_RXDATA    12'h008
`define SEBF_OFF_TXDATA    12'h00c

`define SEBF_CTRL_EN_BIT   0
`define SEBF_CTRL_RST      1'b1

`define SEBF_STS_STANDBY   0
`define SEBF_STS_BUSY      1
`define SEBF_STS_ACTIVE    2
`define SEBF_STS_READ      3
`define SEBF_STS_TOP       4
`define SEBF_STS_WP        5
`define SEBF_STS_RXV       6

`define SEBF_TYPE_CODE     4'ha
`define SEBF_WORD_BITS     4'h8
`define SEBF_LAST_OUT_BIT  4'h7
`define SEBF_ADDR_WORDS    2'h2
`define SEBF_WR_FULL       2'h3

`define SEBF_TWR_MS        5
`define SEBF_CLK_KHZ       125000
`define SEBF_TWR_CYCLES    (`SEBF_TWR_MS * `SEBF_CLK_KHZ)
`define SEBF_BUSY_W        20

`endif

// *** common/sebf_pkg.sv ***
/*
  types of the serial memory bus front end: serial states, pin group and
  the state record of the core.
  assumes: sebf_defs.svh is on the include path.
*/
package sebf_pkg;
  `include "sebf_defs.svh"

  typedef enum logic [2:0] {
    SEBF_ST_IDLE = 3'b000,
    SEBF_ST_ADDR = 3'b001,
    SEBF_ST_AACK = 3'b010,
    SEBF_ST_WR   = 3'b011,
    SEBF_ST_WACK = 3'b100,
    SEBF_ST_RD   = 3'b101,
    SEBF_ST_RACK = 3'b110
  } sebf_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic cs_hi;
    logic cs_lo;
    logic wp;
  } sebf_pins_s;

  typedef struct packed {
    sebf_state_e             st;
    logic [3:0]              bit_cnt;
    logic [7:0]              sh;
    logic                    rd;
    logic                    top;
    logic [1:0]              wr_words;
    logic                    mack;
    logic [`SEBF_BUSY_W-1:0] busy_cnt;
    logic                    enable;
    logic [7:0]              tx;
    logic [7:0]              rx;
    logic                    rx_valid;
    logic                    scl_q;
    logic                    sda_q;
    logic                    sda_oe;
    logic                    sda_out;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } sebf_core_s;
endpackage : sebf_pkg

// *** src/sebf_sync.sv ***
/*
  two-stage synchroniser for a group of asynchronous levels.
  assumes: inputs are quasi-static or single-bit meaningful; q is read only
  by logic in the pclk domain.
*/
`timescale 1ns/1ps
module sebf_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sebf_sync_s;

  sebf_sync_s r;
  sebf_sync_s r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = d;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign q = r.s2;
endmodule : sebf_sync

// *** src/sebf_front_end.sv ***
/*
  two-wire serial memory target front end with an apb register port:
  start/stop detection, 8-bit shifting with ninth-clock acknowledge,
  device address decode, write protect, self-timed write interval.
  assumes: pclk 125 MHz far above the serial clock; pads give the
  open-drain wire and pull-downs on select and protect pins.
*/
// The register offsets and register access over APB were chosen for this implementation.
// Notes on behaviour
// R1: master changes data only while clock low
// R2: falling data, clock high, is start
// R3: rising data, clock high, stops transfer
// R4: 8-bit words, acknowledge low in ninth clock
// R5: standby after power-up, read stop, write end
// R6: start, nine clocks, start, stop recovers bus
// R7: address word top nibble is type code
// R8: two select bits compared with select pins
// R9: unconnected select pin counts as low
// R10: seventh address bit is word address top
// R11: eighth address bit one reads, zero writes
// R12: match acknowledges, mismatch returns to standby
// R13: protect pin high blocks array writes
// R14: write interval at most five milliseconds
// R15: sample on clock rise, drive after fall
// R16: no address acknowledge during write interval
// R17: protect pin low allows normal writes
// R18: lines synchronised, edges found on samples
// R19: data line released except ack or read
`timescale 1ns/1ps
`include "sebf_defs.svh"
module sebf_front_end #(
  parameter int WRITE_CYCLES = `SEBF_TWR_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        chip_select_bit_low,
  input  wire logic        chip_select_bit_high,
  input  wire logic        write_protect_pin
);
  sebf_pkg::sebf_core_s r;
  sebf_pkg::sebf_core_s r_nxt;
  sebf_pkg::sebf_pins_s pins_raw;
  sebf_pkg::sebf_pins_s s;

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_ok;
  logic apb_take;
  logic apb_done;
  logic standby;

  // type nibble, select bits against pins; bit 1 is the word address top
  function automatic logic addr_match(input logic [7:0] w,
                                      input logic       hi,
                                      input logic       lo);
    addr_match = (w[7:4] == `SEBF_TYPE_CODE) && (w[3] == hi) && (w[2] == lo);
  endfunction : addr_match

  function automatic logic [31:0] status_word(input sebf_pkg::sebf_core_s c,
                                              input logic                 wp,
                                              input logic                 sb);
    logic [31:0] w;
    w                   = '0;
    w[`SEBF_STS_STANDBY] = sb;
    w[`SEBF_STS_BUSY]    = (c.busy_cnt != '0);
    w[`SEBF_STS_ACTIVE]  = (c.st != sebf_pkg::SEBF_ST_IDLE);
    w[`SEBF_STS_READ]    = c.rd;
    w[`SEBF_STS_TOP]     = c.top;
    w[`SEBF_STS_WP]      = wp;
    w[`SEBF_STS_RXV]     = c.rx_valid;
    status_word          = w;
  endfunction : status_word

  assign pins_raw = '{scl: scl_in, sda: sda_in, cs_hi: chip_select_bit_high,
                      cs_lo: chip_select_bit_low, wp: write_protect_pin};

  // R18 two-flop sampling of every pin
  sebf_sync #(
    .W ($bits(sebf_pkg::sebf_pins_s))
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pins_raw),
    .q       (s)
  );

  // R18 edges and bus conditions from synchronised samples
  assign scl_rise = s.scl & ~r.scl_q;
  assign scl_fall = ~s.scl & r.scl_q;
  // R2 falling data while clock stays high
  assign start_ev = r.sda_q & ~s.sda & s.scl & r.scl_q;
  // R3 rising data while clock stays high
  assign stop_ev  = ~r.sda_q & s.sda & s.scl & r.scl_q;
  // R9 floating select pins read low through the pad pull-downs
  assign addr_ok  = addr_match(r.sh, s.cs_hi, s.cs_lo) && r.enable && (r.busy_cnt == '0);
  // R5 standby when idle and no write interval running
  assign standby  = (r.st == sebf_pkg::SEBF_ST_IDLE) && (r.busy_cnt == '0);
  assign apb_take = psel & penable & ~r.pready;
  assign apb_done = psel & penable & r.pready;

  always_comb begin
    r_nxt         = r;
    r_nxt.scl_q   = s.scl;
    r_nxt.sda_q   = s.sda;
    r_nxt.sda_out = 1'b0;
    r_nxt.pready  = 1'b0;
    r_nxt.pslverr = 1'b0;

    // R14 self-timed write interval counts down to standby
    if (r.busy_cnt != '0) begin
      r_nxt.busy_cnt = r.busy_cnt - 1'b1;
    end

    // register port: answer one cycle into the access phase
    if (apb_take) begin
      r_nxt.pready = 1'b1;
      r_nxt.prdata = '0;
      case (paddr)
        `SEBF_OFF_CTRL: begin
          r_nxt.prdata[`SEBF_CTRL_EN_BIT] = r.enable;
        end
        `SEBF_OFF_STATUS: begin
          r_nxt.prdata = status_word(r, s.wp, standby);
        end
        `SEBF_OFF_RXDATA: begin
          r_nxt.prdata[7:0] = r.rx;
        end
        `SEBF_OFF_TXDATA: begin
          r_nxt.prdata[7:0] = r.tx;
        end
        default: begin
          r_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_done && pwrite) begin
      if (paddr == `SEBF_OFF_CTRL) begin
        r_nxt.enable = pwdata[`SEBF_CTRL_EN_BIT];
      end
      if (paddr == `SEBF_OFF_TXDATA) begin
        r_nxt.tx = pwdata[7:0];
      end
    end
    // read clears the flag; a byte landing in the same cycle sets it again below
    if (apb_done && !pwrite && (paddr == `SEBF_OFF_RXDATA)) begin
      r_nxt.rx_valid = 1'b0;
    end

    case (r.st)
      sebf_pkg::SEBF_ST_ADDR, sebf_pkg::SEBF_ST_WR: begin
        // R15 capture on the clock rise
        if (scl_rise && (r.bit_cnt < `SEBF_WORD_BITS)) begin
          r_nxt.sh      = {r.sh[6:0], s.sda};
          r_nxt.bit_cnt = r.bit_cnt + 4'h1;
        end
        if (scl_fall && (r.bit_cnt == `SEBF_WORD_BITS)) begin
          r_nxt.bit_cnt = '0;
          if (r.st == sebf_pkg::SEBF_ST_ADDR) begin
            // R7 R8 R12 R16 acknowledge only a matching, idle device
            if (addr_ok) begin
              r_nxt.st       = sebf_pkg::SEBF_ST_AACK;
              r_nxt.sda_oe   = 1'b1;
              // R11 direction bit
              r_nxt.rd       = r.sh[0];
              // R10 word address top bit
              r_nxt.top      = r.sh[1];
              r_nxt.wr_words = '0;
            end else begin
              r_nxt.st = sebf_pkg::SEBF_ST_IDLE;
            end
          end else begin
            r_nxt.rx       = r.sh;
            r_nxt.rx_valid = 1'b1;
            // R13 R17 data words refused while protect pin is high
            if (s.wp && (r.wr_words >= `SEBF_ADDR_WORDS)) begin
              r_nxt.st       = sebf_pkg::SEBF_ST_IDLE;
              r_nxt.wr_words = '0;
            end else begin
              // R4 acknowledge each received word
              r_nxt.st     = sebf_pkg::SEBF_ST_WACK;
              r_nxt.sda_oe = 1'b1;
              if (r.wr_words != `SEBF_WR_FULL) begin
                r_nxt.wr_words = r.wr_words + 2'h1;
              end
            end
          end
        end
      end
      sebf_pkg::SEBF_ST_AACK: begin
        if (scl_fall) begin
          r_nxt.bit_cnt = '0;
          if (r.rd) begin
            // R15 first read bit driven after the fall
            r_nxt.st     = sebf_pkg::SEBF_ST_RD;
            r_nxt.sh     = r.tx;
            r_nxt.sda_oe = ~r.tx[7];
          end else begin
            r_nxt.st     = sebf_pkg::SEBF_ST_WR;
            r_nxt.sda_oe = 1'b0;
          end
        end
      end
      sebf_pkg::SEBF_ST_WACK: begin
        // R19 release at the end of the ninth clock
        if (scl_fall) begin
          r_nxt.st     = sebf_pkg::SEBF_ST_WR;
          r_nxt.sda_oe = 1'b0;
        end
      end
      sebf_pkg::SEBF_ST_RD: begin
        if (scl_fall) begin
          if (r.bit_cnt == `SEBF_LAST_OUT_BIT) begin
            r_nxt.st     = sebf_pkg::SEBF_ST_RACK;
            r_nxt.sda_oe = 1'b0;
          end else begin
            r_nxt.sh      = {r.sh[6:0], 1'b0};
            r_nxt.sda_oe  = ~r.sh[6];
            r_nxt.bit_cnt = r.bit_cnt + 4'h1;
          end
        end
      end
      sebf_pkg::SEBF_ST_RACK: begin
        if (scl_rise) begin
          r_nxt.mack = ~s.sda;
        end
        if (scl_fall) begin
          r_nxt.bit_cnt = '0;
          if (r.mack) begin
            r_nxt.st     = sebf_pkg::SEBF_ST_RD;
            r_nxt.sh     = r.tx;
            r_nxt.sda_oe = ~r.tx[7];
          end else begin
            r_nxt.st = sebf_pkg::SEBF_ST_IDLE;
          end
        end
      end
      default: begin
        r_nxt.sda_oe = 1'b0;
      end
    endcase

    // R2 R6 a start aborts anything and expects an address
    if (start_ev) begin
      r_nxt.st      = sebf_pkg::SEBF_ST_ADDR;
      r_nxt.bit_cnt = '0;
      r_nxt.sda_oe  = 1'b0;
    end else if (stop_ev) begin
      // R3 R5 stop ends the transfer into idle; standby once no write interval runs
      r_nxt.st     = sebf_pkg::SEBF_ST_IDLE;
      r_nxt.sda_oe = 1'b0;
      // R14 a completed unprotected write starts the interval
      if ((r.st == sebf_pkg::SEBF_ST_WR) && (r.wr_words == `SEBF_WR_FULL) &&
          !s.wp && (r.busy_cnt == '0)) begin
        r_nxt.busy_cnt = WRITE_CYCLES[`SEBF_BUSY_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.enable <= `SEBF_CTRL_RST;
    end else begin
      r <= r_nxt;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign sda_out = r.sda_out;
  assign sda_oe  = r.sda_oe;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_addr_done;
    (r.st == sebf_pkg::SEBF_ST_ADDR) && scl_fall && (r.bit_cnt == `SEBF_WORD_BITS);
  endsequence

  sequence s_data_done;
    (r.st == sebf_pkg::SEBF_ST_WR) && scl_fall && (r.bit_cnt == `SEBF_WORD_BITS);
  endsequence

  chk_start_to_addr: assert property ( // R2
    start_ev |=> (r.st == sebf_pkg::SEBF_ST_ADDR) && (r.bit_cnt == '0) && !r.sda_oe)
    else $error("start did not open address phase");

  chk_stop_to_idle: assert property ( // R3
    stop_ev |=> (r.st == sebf_pkg::SEBF_ST_IDLE) && !r.sda_oe)
    else $error("stop did not end transfer");

  chk_addr_match_ack: assert property ( // R12
    s_addr_done ##0 addr_ok |=> (r.st == sebf_pkg::SEBF_ST_AACK) && r.sda_oe && (r.rd == $past(r.sh[0])))
    else $error("matching address not acknowledged");

  chk_addr_miss_idle: assert property ( // R12
    s_addr_done ##0 !addr_ok |=> (r.st == sebf_pkg::SEBF_ST_IDLE) && !r.sda_oe)
    else $error("mismatched address was acknowledged");

  chk_busy_no_ack: assert property ( // R16
    s_addr_done ##0 (r.busy_cnt != '0) |=> !r.sda_oe)
    else $error("address acknowledged during write interval");

  chk_ack_held_ninth: assert property ( // R4
    (r.st == sebf_pkg::SEBF_ST_WACK) && !scl_fall && !start_ev && !stop_ev |=> r.sda_oe)
    else $error("acknowledge dropped inside ninth clock");

  chk_protect_blocks: assert property ( // R13
    s_data_done ##0 (s.wp && (r.wr_words >= `SEBF_ADDR_WORDS)) |=> !r.sda_oe ##1 !r.sda_oe)
    else $error("protected data word was acknowledged");

  chk_line_released: assert property ( // R19
    r.sda_oe |-> (r.st inside {sebf_pkg::SEBF_ST_AACK, sebf_pkg::SEBF_ST_WACK, sebf_pkg::SEBF_ST_RD}))
    else $error("data line driven outside ack or read");

  chk_write_time_load: assert property ( // R14
    $rose(r.busy_cnt != '0) |-> (r.busy_cnt == WRITE_CYCLES[`SEBF_BUSY_W-1:0]) && $past(stop_ev))
    else $error("write interval not loaded from stop");

  chk_rise_capture: assert property ( // R15
    scl_rise && (r.st == sebf_pkg::SEBF_ST_ADDR) && (r.bit_cnt < `SEBF_WORD_BITS) && !start_ev
    |=> (r.bit_cnt == $past(r.bit_cnt) + 4'h1) && (r.sh[0] == $past(s.sda)))
    else $error("bit not captured on clock rise");
endmodule : sebf_front_end

// *** testbench/sebf_master_model.sv ***
/*
  two-wire bus master model: start, stop, byte out with ack, byte in.
  assumes: sda_in is the resolved wire with its pull-up; sda high means
  released; clock stands high outside frames.
*/
`timescale 1ns/1ps
module sebf_master_model (
  input  wire logic pclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask : w

  task automatic start();
    sda <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(10);
    sda <= 1'b0;
    w(10);
    scl <= 1'b0;
    w(2);
  endtask : start

  task automatic stop();
    sda <= 1'b0;
    w(8);
    scl <= 1'b1;
    w(10);
    sda <= 1'b1;
    w(10);
  endtask : stop

  task automatic bit_io(input logic b, output logic r);
    sda <= b;
    w(8);
    scl <= 1'b1;
    w(5);
    r = sda_in;
    w(5);
    scl <= 1'b0;
    w(2);
  endtask : bit_io

  task automatic put(input logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], a);
    end
    bit_io(1'b1, a);
  endtask : put

  task automatic get(input logic m, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, x);
      d[i] = x;
    end
    bit_io(m, x);
  endtask : get
endmodule : sebf_master_model

// *** testbench/sebf_front_end_tb_top.sv ***
/*
  self-checking bench of the serial memory front end: apb master, bus
  master model, address table, write interval, protect, soft reset.
  assumes: sebf_defs.svh on the include path; pull-up on the data wire.
*/
`timescale 1ns/1ps
`include "sebf_defs.svh"
module sebf_front_end_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic       ack;
  } sebf_row_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        scl, m_sda, sda_w, sda_out, sda_oe, cs_lo, cs_hi, wp, a, e;
  logic [7:0]  d;
  int          error_cnt, check_count, n;
  // ack level 0 means acknowledged
  sebf_row_s   rows [8] = '{'{8'ha4, 1'b0}, '{8'ha6, 1'b0}, '{8'ha5, 1'b0}, '{8'ha7, 1'b0},
                            '{8'ha0, 1'b1}, '{8'hac, 1'b1}, '{8'hb4, 1'b1}, '{8'h24, 1'b1}};

  // open drain: the device only ever pulls low, otherwise the master's sda level wins
  assign sda_w = sda_oe ? sda_out : m_sda;

  sebf_front_end #(.WRITE_CYCLES(600)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_bit_low(cs_lo), .chip_select_bit_high(cs_hi), .write_protect_pin(wp));

  sebf_master_model mm_u (.pclk(pclk), .sda_in(sda_w), .scl(scl), .sda(m_sda));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk_bit

  // request held until pready is seen at an edge
  task automatic apb(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    #500000;
    error_cnt++;
    results();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cs_lo = 1'b1;
    cs_hi = 1'b0;
    wp = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(`SEBF_OFF_CTRL, 1'b0, 32'h0);
    chk_word(q, 32'h1);
    apb(`SEBF_OFF_STATUS, 1'b0, 32'h0);
    chk_bit(q[0], 1'b1);
    apb(`SEBF_OFF_TXDATA, 1'b1, 32'h5a);
    $display("reset test done");
    foreach (rows[i]) begin
      mm_u.start();
      mm_u.put(rows[i].a, a);
      chk_bit(a, rows[i].ack);
      if (!rows[i].ack && rows[i].a[0]) begin
        // master ack reloads the byte, the nack after it ends the read
        mm_u.get(1'b0, d);
        chk_word({24'h0, d}, 32'h5a);
        mm_u.get(1'b1, d);
        chk_word({24'h0, d}, 32'h5a);
      end
      mm_u.stop();
      chk_bit(sda_oe, 1'b0);
      chk_bit(sda_out, 1'b0);
      apb(`SEBF_OFF_STATUS, 1'b0, 32'h0);
      if (!rows[i].ack) begin
        chk_word(q & 32'h1c, {27'h0, rows[i].a[1], rows[i].a[0], 3'b000});
      end
      $display("row %0d done", i);
    end
    mm_u.start();
    mm_u.put(8'ha4, a);
    mm_u.put(8'h01, a);
    mm_u.put(8'h23, a);
    mm_u.put(8'hc5, a);
    chk_bit(a, 1'b0);
    mm_u.stop();
    apb(`SEBF_OFF_STATUS, 1'b0, 32'h0);
    chk_bit(q[1], 1'b1);
    chk_bit(q[6], 1'b1);
    apb(`SEBF_OFF_RXDATA, 1'b0, 32'h0);
    chk_word(q, 32'hc5);
    mm_u.start();
    mm_u.put(8'ha4, a);
    chk_bit(a, 1'b1);
    mm_u.stop();
    n = 0;
    do begin
      apb(`SEBF_OFF_STATUS, 1'b0, 32'h0);
      n++;
    end while (q[1] !== 1'b0 && n < 200);
    chk_bit(q[1], 1'b0);
    chk_bit(q[6], 1'b0);
    chk_bit(q[0], 1'b1);
    mm_u.start();
    mm_u.put(8'ha4, a);
    chk_bit(a, 1'b0);
    mm_u.stop();
    $display("write interval test done");
    wp <= 1'b1;
    mm_u.start();
    mm_u.put(8'ha4, a);
    mm_u.put(8'h01, a);
    mm_u.put(8'h23, a);
    chk_bit(a, 1'b0);
    mm_u.put(8'hc5, a);
    chk_bit(a, 1'b1);
    mm_u.stop();
    wp <= 1'b0;
    apb(`SEBF_OFF_STATUS, 1'b0, 32'h0);
    chk_bit(q[1], 1'b0);
    $display("protect test done");
    apb(`SEBF_OFF_CTRL, 1'b1, 32'h0);
    mm_u.start();
    mm_u.put(8'ha4, a);
    chk_bit(a, 1'b1);
    mm_u.stop();
    apb(`SEBF_OFF_CTRL, 1'b1, 32'h1);
    apb(12'h010, 1'b0, 32'h0);
    chk_bit(e, 1'b1);
    chk_word(q, 32'h0);
    $display("register test done");
    mm_u.start();
    mm_u.bit_io(1'b1, a);
    mm_u.bit_io(1'b0, a);
    mm_u.start();
    repeat (9) mm_u.bit_io(1'b1, a);
    mm_u.start();
    mm_u.stop();
    cs_lo <= 1'b0;
    mm_u.start();
    mm_u.put(8'ha0, a);
    chk_bit(a, 1'b0);
    mm_u.stop();
    $display("soft reset test done");
    // mid-run reset must undo a software disable and land in standby
    apb(`SEBF_OFF_CTRL, 1'b1, 32'h0);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(`SEBF_OFF_CTRL, 1'b0, 32'h0);
    chk_word(q, 32'h1);
    apb(`SEBF_OFF_STATUS, 1'b0, 32'h0);
    chk_word(q, 32'h1);
    mm_u.start();
    mm_u.put(8'ha0, a);
    chk_bit(a, 1'b0);
    mm_u.stop();
    $display("mid-run reset test done");
    results();
  end
endmodule : sebf_front_end_tb_top
